/* File: logic/pcd_control.sv */
/*
 * pcd_control: register bank for pump gain and offset, phase comparator
 * features and reference buffer mode, decoded into analog controls.
 * Assumes the serial port deserialiser outside delivers whole 24-bit words
 * with an address and a one-cycle write or read strobe, synchronous to clk_in.
 */
// Overview of operation
// - up and down pump gains from fields
// - offset magnitude and up/down enables from fields
// - mask bit 5 low blocks up
// - mask bit 6 low blocks down
// - both masks low: pump high impedance
// - a single force bit drives pump up or down over the masks; both force bits set are ignored
// - bit 21 selects reference buffer mode
`timescale 1ns/1ns
`default_nettype none
module pcd_control (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [pcd_pkg::PCD_ADDR_W-1:0] reg_addr_in,
    input wire logic [pcd_pkg::PCD_DATA_W-1:0] reg_wdata_in,
    input wire logic comparator_up_in,
    input wire logic comparator_dn_in,
    output logic [pcd_pkg::PCD_DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic [pcd_pkg::PCD_GAIN_W-1:0] pump_source_gain_out,
    output logic [pcd_pkg::PCD_GAIN_W-1:0] pump_sink_gain_out,
    output logic [pcd_pkg::PCD_GAIN_W-1:0] pump_bias_current_out,
    output logic pump_bias_up_en_out,
    output logic pump_bias_dn_en_out,
    output logic pump_source_out,
    output logic pump_sink_out,
    output logic pump_hiz_out,
    output logic ref_buf_high_freq_out
);
    import pcd_pkg::*;

    logic [PCD_DATA_W-1:0] ref_buf_reg;
    logic [PCD_DATA_W-1:0] ref_buf_next;
    logic [PCD_DATA_W-1:0] pump_reg;
    logic [PCD_DATA_W-1:0] pump_next;
    logic [PCD_DATA_W-1:0] det_reg;
    logic [PCD_DATA_W-1:0] det_next;
    logic [PCD_DATA_W-1:0] rdata_reg;
    logic [PCD_DATA_W-1:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    pcd_steer_if steer_bus ();

    function automatic logic addr_is(input logic [PCD_ADDR_W-1:0] addr, input logic [PCD_ADDR_W-1:0] ofs);
        addr_is = (addr == ofs);
    endfunction : addr_is

    // register writes and reads; unmapped reads return zero, writes dropped
    always_comb begin
        ref_buf_next = ref_buf_reg;
        pump_next = pump_reg;
        det_next = det_reg;
        if (reg_wr_in && addr_is(reg_addr_in, PCD_REF_BUF_OFS)) begin
            ref_buf_next = reg_wdata_in;
        end
        if (reg_wr_in && addr_is(reg_addr_in, PCD_PUMP_OFS)) begin
            pump_next = reg_wdata_in;
        end
        if (reg_wr_in && addr_is(reg_addr_in, PCD_DET_OFS)) begin
            det_next = reg_wdata_in;
        end
        rvalid_next = reg_rd_in;
        rdata_next = rdata_reg;
        if (reg_rd_in) begin
            if (addr_is(reg_addr_in, PCD_REF_BUF_OFS)) begin
                rdata_next = ref_buf_reg;
            end else if (addr_is(reg_addr_in, PCD_PUMP_OFS)) begin
                rdata_next = pump_reg;
            end else if (addr_is(reg_addr_in, PCD_DET_OFS)) begin
                // force bits read back as stored, not as applied
                rdata_next = det_reg;
            end else begin
                rdata_next = PCD_READ_NONE;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_buf_reg <= PCD_REF_BUF_RST;
            pump_reg <= PCD_PUMP_RST;
            det_reg <= PCD_DET_RST;
            rdata_reg <= PCD_READ_NONE;
            rvalid_reg <= 1'b0;
        end else begin
            ref_buf_reg <= ref_buf_next;
            pump_reg <= pump_next;
            det_reg <= det_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // host keeps gains equal and offset legal; no checking is done here
    assign pump_source_gain_out = pump_reg[PCD_GAIN_SOURCE_LSB +: PCD_GAIN_W];
    assign pump_sink_gain_out = pump_reg[PCD_GAIN_SINK_LSB +: PCD_GAIN_W];
    assign pump_bias_current_out = pump_reg[PCD_BIAS_MAG_LSB +: PCD_GAIN_W];
    assign pump_bias_up_en_out = pump_reg[PCD_BIAS_UP_BIT];
    assign pump_bias_dn_en_out = pump_reg[PCD_BIAS_DN_BIT];
    assign ref_buf_high_freq_out = ref_buf_reg[PCD_BUF_MODE_BIT];

    assign steer_bus.pass_up = det_reg[PCD_MASK_UP_BIT];
    assign steer_bus.pass_dn = det_reg[PCD_MASK_DN_BIT];
    assign steer_bus.force_up = det_reg[PCD_FORCE_UP_BIT];
    assign steer_bus.force_dn = det_reg[PCD_FORCE_DN_BIT];

    pcd_pump_steer u_steer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .comparator_up_in(comparator_up_in),
        .comparator_dn_in(comparator_dn_in),
        .steer_if(steer_bus.steer)
    );

    assign pump_source_out = steer_bus.pump_source;
    assign pump_sink_out = steer_bus.pump_sink;
    assign pump_hiz_out = steer_bus.pump_hiz;
    assign reg_rdata_out = rdata_reg;
    assign reg_rvalid_out = rvalid_reg;
endmodule : pcd_control
`default_nettype wire

/* File: logic/pcd_pkg.sv */
/*
 * pcd_pkg: register offsets, field positions and reset values of the pump,
 * phase comparator and reference buffer settings.
 * Assumes 24-bit registers reached by an 8-bit register address.
 */
package pcd_pkg;
    localparam int unsigned PCD_DATA_W = 24;
    localparam int unsigned PCD_ADDR_W = 8;
    localparam int unsigned PCD_GAIN_W = 7;

    // register offsets
    localparam logic [7:0] PCD_REF_BUF_OFS = 8'h08;
    localparam logic [7:0] PCD_PUMP_OFS = 8'h09;
    localparam logic [7:0] PCD_DET_OFS = 8'h0b;

    // pump_gain_offset_control fields
    localparam int unsigned PCD_GAIN_SINK_LSB = 0;
    localparam int unsigned PCD_GAIN_SOURCE_LSB = 7;
    localparam int unsigned PCD_BIAS_MAG_LSB = 14;
    localparam int unsigned PCD_BIAS_UP_BIT = 21;
    localparam int unsigned PCD_BIAS_DN_BIT = 22;

    // detector_feature_control fields
    localparam int unsigned PCD_MASK_UP_BIT = 5;
    localparam int unsigned PCD_MASK_DN_BIT = 6;
    localparam int unsigned PCD_FORCE_UP_BIT = 9;
    localparam int unsigned PCD_FORCE_DN_BIT = 10;

    // reference_buffer_config fields
    localparam int unsigned PCD_BUF_MODE_BIT = 21;

    // reset values: pump gains zero, offset off, both comparator outputs passed
    localparam logic [23:0] PCD_REF_BUF_RST = 24'h000000;
    localparam logic [23:0] PCD_PUMP_RST = 24'h000000;
    localparam logic [23:0] PCD_DET_RST = 24'h000060;
    localparam logic [23:0] PCD_READ_NONE = 24'h000000;
endpackage : pcd_pkg

/* File: logic/pcd_steer_if.sv */
/*
 * pcd_steer_if: carries detector mask and force settings from the register
 * bank to the pump steering logic and the steered pump controls back.
 * Assumes both ends run on the same register clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface pcd_steer_if;
    logic pass_up;
    logic pass_dn;
    logic force_up;
    logic force_dn;
    logic pump_source;
    logic pump_sink;
    logic pump_hiz;

    modport bank (
        output pass_up,
        output pass_dn,
        output force_up,
        output force_dn,
        input pump_source,
        input pump_sink,
        input pump_hiz
    );

    modport steer (
        input pass_up,
        input pass_dn,
        input force_up,
        input force_dn,
        output pump_source,
        output pump_sink,
        output pump_hiz
    );
endinterface : pcd_steer_if
`default_nettype wire

/* File: logic/pcd_pump_steer.sv */
/*
 * pcd_pump_steer: gates the phase comparator up/down pulses with the mask
 * bits, applies the force overrides and registers the pump controls.
 * Assumes comparator pulses synchronous to clk_in.
 */
`timescale 1ns/1ns
`default_nettype none
module pcd_pump_steer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic comparator_up_in,
    input wire logic comparator_dn_in,
    pcd_steer_if.steer steer_if
);
    logic source_reg;
    logic source_next;
    logic sink_reg;
    logic sink_next;
    logic hiz_reg;
    logic hiz_next;
    logic one_force;

    always_comb begin
        // both forces together cancel out
        one_force = steer_if.force_up ^ steer_if.force_dn;
        if (one_force) begin
            source_next = steer_if.force_up;
            sink_next = steer_if.force_dn;
            hiz_next = 1'b0;
        end else begin
            source_next = comparator_up_in & steer_if.pass_up;
            sink_next = comparator_dn_in & steer_if.pass_dn;
            hiz_next = ~steer_if.pass_up & ~steer_if.pass_dn;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            source_reg <= 1'b0;
            sink_reg <= 1'b0;
            hiz_reg <= 1'b0;
        end else begin
            source_reg <= source_next;
            sink_reg <= sink_next;
            hiz_reg <= hiz_next;
        end
    end

    assign steer_if.pump_source = source_reg;
    assign steer_if.pump_sink = sink_reg;
    assign steer_if.pump_hiz = hiz_reg;
endmodule : pcd_pump_steer
`default_nettype wire

/* File: testbench/pcd_control_asserts.sv */
/* pcd_control_asserts: port checker for pcd_control, bound below.
   assumes one clock, writes seen one edge later, pump outputs one edge late. */
`timescale 1ns/1ns
`default_nettype none
module pcd_control_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [23:0] reg_wdata_in,
    input wire logic comparator_up_in,
    input wire logic comparator_dn_in,
    input wire logic [6:0] pump_source_gain_out,
    input wire logic [6:0] pump_sink_gain_out,
    input wire logic [6:0] pump_bias_current_out,
    input wire logic pump_bias_up_en_out,
    input wire logic pump_bias_dn_en_out,
    input wire logic pump_source_out,
    input wire logic pump_sink_out,
    input wire logic pump_hiz_out,
    input wire logic ref_buf_high_freq_out
);
    logic [10:0] det_reg, det_next;
    logic wr_pump, one_force, src_exp, snk_exp;
    always_comb begin
        det_next = det_reg;
        if (reg_wr_in && reg_addr_in == 8'h0b) det_next = reg_wdata_in[10:0];
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) det_reg <= 11'h060;
        else det_reg <= det_next;
    end
    assign wr_pump = reg_wr_in && reg_addr_in == 8'h09;
    assign one_force = det_reg[9] ^ det_reg[10];
    assign src_exp = comparator_up_in & det_reg[5];
    assign snk_exp = comparator_dn_in & det_reg[6];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_GAIN: assert property (wr_pump |=>
        {pump_source_gain_out, pump_sink_gain_out} == $past(reg_wdata_in[13:0])) else $error("gain wrong");
    AST_BIAS: assert property (wr_pump |=>
        {pump_bias_dn_en_out, pump_bias_up_en_out, pump_bias_current_out} == $past(reg_wdata_in[22:14]))
        else $error("bias wrong");
    AST_REF_MODE: assert property (reg_wr_in && reg_addr_in == 8'h08 |=>
        ref_buf_high_freq_out == $past(reg_wdata_in[21])) else $error("buffer mode wrong");
    AST_MASK_UP: assert property (!one_force && !det_reg[5] |=> !pump_source_out)
        else $error("up not masked");
    AST_MASK_DN: assert property (!one_force && !det_reg[6] |=> !pump_sink_out)
        else $error("down not masked");
    AST_HIZ: assert property (!one_force && det_reg[6:5] == 2'b00 |=> pump_hiz_out)
        else $error("pump not released");
    AST_FORCE: assert property (one_force |=> pump_source_out == $past(det_reg[9]) &&
        pump_sink_out == $past(det_reg[10]) && !pump_hiz_out) else $error("force ignored");
    AST_BOTH: assert property (&det_reg[10:9] |=> pump_source_out == $past(src_exp) &&
        pump_sink_out == $past(snk_exp)) else $error("double force not masked");
    cover property (one_force);
    cover property (&det_reg[10:9] && src_exp);
    cover property (det_reg[6:5] == 2'b00);
endmodule : pcd_control_asserts
bind pcd_control pcd_control_asserts u_pcd_control_asserts (.*);
`default_nettype wire

/* File: testbench/pcd_host_model.sv */
/* pcd_host_model: host issuing word writes and reads at the falling edge.
   assumes strobes are taken on the next rising clk_in. */
`timescale 1ns/1ns
`default_nettype none
module pcd_host_model (
    input wire logic clk_in,
    output var logic reg_wr_out,
    output var logic reg_rd_out,
    output var logic [7:0] reg_addr_out,
    output var logic [23:0] reg_wdata_out
);
    initial {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = '0;
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(negedge clk_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge clk_in);
        reg_wr_out = 1'b0;
        // idle data must not look like the last word
        reg_wdata_out = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clk_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge clk_in);
        reg_rd_out = 1'b0;
    endtask : rd
endmodule : pcd_host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
/* tb_top: self-checking bench comparing pcd_control with an integer model.
   assumes the host model drives the register port. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    logic clk_in = 1'b0, rst_n_in = 1'b0, comp_up = 1'b0, comp_dn = 1'b0;
    logic wr, rd, rv, psrc, psnk, phiz, rbuf, bup, bdn;
    logic [7:0] addr;
    logic [23:0] wd, rdat;
    logic [6:0] gsrc, gsnk, bias;
    int failures = 0, comparisons = 0, g, model_reg[int];
    integer seed = 19116;
    pcd_host_model u_pcd_host_model (.clk_in, .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
        .reg_wdata_out(wd));
    pcd_control u_pcd_control (.clk_in, .rst_n_in, .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wd), .comparator_up_in(comp_up), .comparator_dn_in(comp_dn), .reg_rdata_out(rdat),
        .reg_rvalid_out(rv), .pump_source_gain_out(gsrc), .pump_sink_gain_out(gsnk), .pump_bias_current_out(bias),
        .pump_bias_up_en_out(bup), .pump_bias_dn_en_out(bdn), .pump_source_out(psrc), .pump_sink_out(psnk),
        .pump_hiz_out(phiz), .ref_buf_high_freq_out(rbuf));
    always #20 clk_in = ~clk_in;
    function automatic logic [2:0] pump_exp(int det, logic u, logic d);
        if (det[9] ^ det[10]) return {det[9], det[10], 1'b0};
        return {u & det[5], d & det[6], !det[5] & !det[6]};
    endfunction : pump_exp
    task automatic put(input int a, input int d);
        u_pcd_host_model.wr(8'(a), 24'(d));
        if (model_reg.exists(a)) model_reg[a] = d;
    endtask : put
    task automatic get(input int a);
        u_pcd_host_model.rd(8'(a));
        `CHK(rv, 1'b1)
        `CHK(rdat, 24'(model_reg.exists(a) ? model_reg[a] : 0))
    endtask : get
    task automatic fields;
        `CHK({gsrc, gsnk}, 14'(model_reg[9]))
        `CHK({bdn, bup, bias}, 9'(model_reg[9] >> 14))
        `CHK(rbuf, 1'(model_reg[8] >> 21))
    endtask : fields
    task automatic restart;
        rst_n_in = 1'b0;
        model_reg = '{8: 0, 9: 0, 11: 'h60};
        repeat (12) @(negedge clk_in);
        `CHK({psrc, psnk, phiz}, 3'b000)
        rst_n_in = 1'b1;
        for (int a = 8; a < 13; a++) get(a);
        fields();
        $display("reset test done");
    endtask : restart
    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        restart();
        for (int i = 0; i < 8; i++) begin
            g = $random(seed) & 127;
            // even passes: integer mode, offset off before each hop; odd: fractional, offset back on
            put(9, (i % 2) * (('h1 << 21) | ((g / 4) << 14)) | (g << 7) | g);
            fields();
            get(9);
        end
        // host breaking the offset advice on purpose, down enable set
        g = $random(seed) & 127;
        put(9, 'h400000 | ((g / 4) << 14) | (g << 7) | g);
        put(8, 'h200000);
        fields();
        put(8, $random(seed) & 'h1fffff);
        fields();
        get(8);
        $display("register test done");
        for (int c = 0; c < 16; c++) begin
            put(11, (c % 2) << 5 | (c / 2 % 2) << 6 | (c / 4 % 2) << 9 | (c / 8) << 10);
            for (int k = 0; k < 6; k++) begin
                comp_up = 1'($random(seed));
                comp_dn = 1'($random(seed));
                @(negedge clk_in);
                `CHK({psrc, psnk, phiz}, pump_exp(model_reg[11], comp_up, comp_dn))
            end
        end
        $display("pump test done");
        restart();
        wrap_up();
    end
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
